// [rtl/amu_regs.vh]
`ifndef AMU_REGS_VH
`define AMU_REGS_VH
// Byte addresses on the register bus
`define AMU_ADDR_CTRL 4'h0
`define AMU_ADDR_BREV 4'h4
`define AMU_ADDR_TPAG 4'h8
`define AMU_ADDR_VPAG 4'hC
// Control and bit-reverse register fields
`define AMU_XSEL_LSB 0
`define AMU_YSEL_LSB 4
`define AMU_BSEL_LSB 8
`define AMU_YEN_BIT 14
`define AMU_XEN_BIT 15
`define AMU_BITREV_ENABLE_BIT 15
`define AMU_PTR_OFF 4'hF
// Reset values
`define AMU_CTRL_RST 16'h0FFF
`define AMU_BREV_RST 16'h0000
`define AMU_TPAG_RST 8'h00
`define AMU_VPAG_RST 8'h00
// Addressing modes from the core
`define AMU_MODE_IND 3'h0
`define AMU_MODE_POSTINC 3'h1
`define AMU_MODE_PREINC 3'h2
`define AMU_MODE_POSTDEC 3'h3
`define AMU_MODE_PREDEC 3'h4
`define AMU_MODE_REGOFF 3'h5
`define AMU_VIS_BIT 2
`endif

// [rtl/amu_addr_mod.v]
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
// Contract
// [R1] X circular pointer select is control bits 3:0; 15 disables X read and write.
// [R2] X circular active when X select is not 15 and control bit 15 set.
// [R3] Y circular pointer select is control bits 7:4; 15 disables Y.
// [R4] Y circular active when Y select is not 15 and Y enable bit set.
// [R5] Boundary test is beyond-limit, less or greater, not just equal.
// [R6] Pointer writeback only for pre or post modify; offset mode keeps pointer.
// [R7] Bit-reversed addressing only in X write generator for data writes.
// [R8] Only the modifier is bit-reversed; pointer and result stay normal order.
// [R9] Bit-reverse needs select not 15, enable bit 15, pre/post increment mode.
// [R10] Modifier is bits 14:0, a word count scaled to byte addresses.
// [R11] Byte writes or other modes fall back to the normal address.
// [R12] Active bit-reverse adds reversed modifier, ignores offset, clears EA bit 0.
// [R13] Bit-reverse wins in X write generator; X read circular still works.
// [R14] Core avoids bit-reverse pointer read right after modifier write.
// [R15] Table address is 8-bit page above 16-bit EA, 24 bits.
// [R16] Table page bit 7 selects user (0) or configuration (1) memory.
// [R17] Window address is visibility page over EA 14:0, bit 23 zero.
// [R18] EA bit 15 unused; program bit 15 comes from page bit 0.
// [R19] Window returns low program word only, reads only.
// [R20] Window active only with core control bit 2 and EA bit 15 set.
// [R21] Start and end registers per space bound each circular buffer.
`include "amu_regs.vh"
module amu_addr_mod #(
  parameter AW = 16
) (
  mclk,
  rst,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  xmod_start,
  xmod_end,
  ymod_start,
  ymod_end,
  core_control,
  xr_valid,
  xr_ptr_sel,
  xr_ptr,
  xr_off,
  xr_mode,
  xw_valid,
  xw_ptr_sel,
  xw_ptr,
  xw_off,
  xw_mode,
  xw_byte,
  y_valid,
  y_ptr_sel,
  y_ptr,
  y_off,
  y_mode,
  tbl_valid,
  tbl_ea,
  dr_valid,
  dr_ea,
  dr_write,
  xr_ea,
  xr_wb_en,
  xr_wb_val,
  xr_out_valid,
  xw_ea,
  xw_wb_en,
  xw_wb_val,
  xw_out_valid,
  xw_brev_act,
  y_ea,
  y_wb_en,
  y_wb_val,
  y_out_valid,
  tbl_paddr,
  tbl_cfg,
  tbl_out_valid,
  win_paddr,
  win_hit,
  win_low_word,
  win_wr_err
);
  input wire mclk;
  input wire rst;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [3:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg [31:0] wb_dat_o;
  output reg wb_ack_o;
  input wire [AW-1:0] xmod_start;
  input wire [AW-1:0] xmod_end;
  input wire [AW-1:0] ymod_start;
  input wire [AW-1:0] ymod_end;
  input wire [15:0] core_control;
  input wire xr_valid;
  input wire [3:0] xr_ptr_sel;
  input wire [AW-1:0] xr_ptr;
  input wire [AW-1:0] xr_off;
  input wire [2:0] xr_mode;
  input wire xw_valid;
  input wire [3:0] xw_ptr_sel;
  input wire [AW-1:0] xw_ptr;
  input wire [AW-1:0] xw_off;
  input wire [2:0] xw_mode;
  input wire xw_byte;
  input wire y_valid;
  input wire [3:0] y_ptr_sel;
  input wire [AW-1:0] y_ptr;
  input wire [AW-1:0] y_off;
  input wire [2:0] y_mode;
  input wire tbl_valid;
  input wire [15:0] tbl_ea;
  input wire dr_valid;
  input wire [15:0] dr_ea;
  input wire dr_write;
  output reg [AW-1:0] xr_ea;
  output reg xr_wb_en;
  output reg [AW-1:0] xr_wb_val;
  output reg xr_out_valid;
  output reg [AW-1:0] xw_ea;
  output reg xw_wb_en;
  output reg [AW-1:0] xw_wb_val;
  output reg xw_out_valid;
  output reg xw_brev_act;
  output reg [AW-1:0] y_ea;
  output reg y_wb_en;
  output reg [AW-1:0] y_wb_val;
  output reg y_out_valid;
  output reg [23:0] tbl_paddr;
  output reg tbl_cfg;
  output reg tbl_out_valid;
  output reg [23:0] win_paddr;
  output reg win_hit;
  output reg win_low_word;
  output reg win_wr_err;

  reg [15:0] ctrl_q;
  reg [15:0] brev_q;
  reg [7:0] tpag_q;
  reg [7:0] vpag_q;
  reg [31:0] rdat_d;

  // EA before correction; the mode picks the add term
  function [AW-1:0] raw_ea;
    input [2:0] mode;
    input [AW-1:0] ptr;
    input [AW-1:0] off;
    begin
      case (mode)
        `AMU_MODE_PREINC, `AMU_MODE_PREDEC, `AMU_MODE_REGOFF: raw_ea = ptr + off;
        default: raw_ea = ptr;
      endcase
    end
  endfunction

  // Updated pointer value for modify modes
  function [AW-1:0] new_ptr;
    input [2:0] mode;
    input [AW-1:0] ptr;
    input [AW-1:0] off;
    begin
      new_ptr = ptr + off;
      if (mode == `AMU_MODE_IND || mode == `AMU_MODE_REGOFF) begin
        new_ptr = ptr;
      end
    end
  endfunction

  // Circular wrap; a step beyond a bound is folded back by the buffer length
  function [AW-1:0] wrap;
    input [AW-1:0] a;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    reg [AW-1:0] len;
    begin
      len = hi - lo + {{(AW-1){1'b0}}, 1'b1};
      wrap = a;
      // [R5] beyond, not equal
      if (a > hi) begin
        wrap = a - len;
      end else if (a < lo) begin
        wrap = a + len;
      end
    end
  endfunction

  // Modes that write the pointer back
  function is_mod;
    input [2:0] mode;
    begin
      is_mod = (mode == `AMU_MODE_POSTINC) || (mode == `AMU_MODE_PREINC) ||
               (mode == `AMU_MODE_POSTDEC) || (mode == `AMU_MODE_PREDEC);
    end
  endfunction

  // Bit mirror; the reverse-carry add needs it on both sides
  function [AW-1:0] rev_bits;
    input [AW-1:0] v;
    integer i;
    begin
      for (i = 0; i < AW; i = i + 1) begin
        rev_bits[i] = v[AW-1-i];
      end
    end
  endfunction

  // Register file, Wishbone classic, one wait state then ack
  // Ack in flight masks the held request, so one strobe is taken once
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `AMU_CTRL_RST;
      brev_q <= `AMU_BREV_RST;
      tpag_q <= `AMU_TPAG_RST;
      vpag_q <= `AMU_VPAG_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rdat_d : 32'h00000000;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `AMU_ADDR_CTRL: begin
            if (wb_sel_i[0]) begin
              ctrl_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              ctrl_q[15:8] <= wb_dat_i[15:8];
            end
          end
          `AMU_ADDR_BREV: begin
            if (wb_sel_i[0]) begin
              brev_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              brev_q[15:8] <= wb_dat_i[15:8];
            end
          end
          `AMU_ADDR_TPAG: begin
            if (wb_sel_i[0]) begin
              tpag_q <= wb_dat_i[7:0];
            end
          end
          `AMU_ADDR_VPAG: begin
            if (wb_sel_i[0]) begin
              vpag_q <= wb_dat_i[7:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Unmapped addresses read zero and writes are dropped
  always @* begin
    case (wb_adr_i)
      `AMU_ADDR_CTRL: rdat_d = {16'h0000, ctrl_q};
      `AMU_ADDR_BREV: rdat_d = {16'h0000, brev_q};
      `AMU_ADDR_TPAG: rdat_d = {24'h000000, tpag_q};
      `AMU_ADDR_VPAG: rdat_d = {24'h000000, vpag_q};
      default: rdat_d = 32'h00000000;
    endcase
  end

  // [R1] X select field
  wire [3:0] xsel = ctrl_q[`AMU_XSEL_LSB+3:`AMU_XSEL_LSB];
  // [R3] Y select field
  wire [3:0] ysel = ctrl_q[`AMU_YSEL_LSB+3:`AMU_YSEL_LSB];
  wire [3:0] bsel = ctrl_q[`AMU_BSEL_LSB+3:`AMU_BSEL_LSB];
  // [R2] X circular enable
  wire xmod_on = (xsel != `AMU_PTR_OFF) & ctrl_q[`AMU_XEN_BIT];
  // [R4] Y circular enable
  wire ymod_on = (ysel != `AMU_PTR_OFF) & ctrl_q[`AMU_YEN_BIT];
  // [R9] bit-reverse enable
  wire brev_on = (bsel != `AMU_PTR_OFF) & brev_q[`AMU_BITREV_ENABLE_BIT];
  // [R9] increment modes only
  wire xw_inc = (xw_mode == `AMU_MODE_PREINC) | (xw_mode == `AMU_MODE_POSTINC);
  // [R7] [R11] write generator only, word writes with increment modes
  wire xw_brev = brev_on & xw_inc & ~xw_byte & (xw_ptr_sel == bsel);
  // [R10] word count scaled to byte address
  wire [AW-1:0] pivot = {brev_q[AW-2:0], 1'b0};
  // [R8] reverse-carry add: only the modifier sense is reversed
  wire [AW-1:0] brev_sum = rev_bits(rev_bits(xw_ptr) + rev_bits(pivot));

  wire [AW-1:0] xr_raw = raw_ea(xr_mode, xr_ptr, xr_off);
  wire [AW-1:0] xr_np = new_ptr(xr_mode, xr_ptr, xr_off);
  // [R13] read side unaffected by bit-reverse
  wire xr_c = xmod_on & (xr_ptr_sel == xsel);

  wire [AW-1:0] xw_raw = raw_ea(xw_mode, xw_ptr, xw_off);
  wire [AW-1:0] xw_np = new_ptr(xw_mode, xw_ptr, xw_off);
  // [R13] bit-reverse disables circular on the write side
  wire xw_c = xmod_on & (xw_ptr_sel == xsel) & ~xw_brev;

  wire [AW-1:0] y_raw = raw_ea(y_mode, y_ptr, y_off);
  wire [AW-1:0] y_np = new_ptr(y_mode, y_ptr, y_off);
  wire y_c = ymod_on & (y_ptr_sel == ysel);
  // [R21] Y buffer bounds
  wire [AW-1:0] y_eac = wrap(y_raw, ymod_start, ymod_end);

  // [R20] window condition
  wire win_d = core_control[`AMU_VIS_BIT] & dr_ea[15] & dr_valid;

  always @(posedge mclk) begin
    if (rst) begin
      xr_ea <= {AW{1'b0}};
      xr_wb_en <= 1'b0;
      xr_wb_val <= {AW{1'b0}};
      xr_out_valid <= 1'b0;
      xw_ea <= {AW{1'b0}};
      xw_wb_en <= 1'b0;
      xw_wb_val <= {AW{1'b0}};
      xw_out_valid <= 1'b0;
      xw_brev_act <= 1'b0;
      y_ea <= {AW{1'b0}};
      y_wb_en <= 1'b0;
      y_wb_val <= {AW{1'b0}};
      y_out_valid <= 1'b0;
      tbl_paddr <= 24'h000000;
      tbl_cfg <= 1'b0;
      tbl_out_valid <= 1'b0;
      win_paddr <= 24'h000000;
      win_hit <= 1'b0;
      win_low_word <= 1'b0;
      win_wr_err <= 1'b0;
    end else begin
      // [R5] [R21] read side keeps circular correction under bit-reverse
      xr_out_valid <= xr_valid;
      xr_ea <= xr_c ? wrap(xr_raw, xmod_start, xmod_end) : xr_raw;
      // [R6] writeback only for modify modes
      xr_wb_en <= xr_valid & is_mod(xr_mode);
      xr_wb_val <= xr_c ? wrap(xr_np, xmod_start, xmod_end) : xr_np;
      xw_out_valid <= xw_valid;
      xw_brev_act <= xw_valid & xw_brev;
      if (xw_brev) begin
        // [R12] offset ignored, bit 0 cleared
        xw_ea <= {xw_ptr[AW-1:1], 1'b0};
        xw_wb_val <= {brev_sum[AW-1:1], 1'b0};
        // [R12] pre-increment addresses through the new pointer
        if (xw_mode == `AMU_MODE_PREINC) begin
          xw_ea <= {brev_sum[AW-1:1], 1'b0};
        end
      end else begin
        // [R11] normal address when bit-reverse does not apply
        xw_ea <= xw_c ? wrap(xw_raw, xmod_start, xmod_end) : xw_raw;
        xw_wb_val <= xw_c ? wrap(xw_np, xmod_start, xmod_end) : xw_np;
      end
      // [R6] write side pointer writeback
      xw_wb_en <= xw_valid & is_mod(xw_mode);
      y_out_valid <= y_valid;
      // Y space data is word sized, so EA bit 0 stays clear under correction
      y_ea <= y_c ? {y_eac[AW-1:1], 1'b0} : y_raw;
      // [R6] Y writeback
      y_wb_en <= y_valid & is_mod(y_mode);
      y_wb_val <= y_c ? wrap(y_np, ymod_start, ymod_end) : y_np;
      // [R15] table address
      tbl_out_valid <= tbl_valid;
      tbl_paddr <= {tpag_q, tbl_ea};
      // [R16] configuration space select
      tbl_cfg <= tpag_q[7];
      // [R17] [R18] window address, bit 23 zero
      win_paddr <= {1'b0, vpag_q, dr_ea[14:0]};
      // [R19] read-only low word; a write into the window is flagged, not passed
      win_hit <= win_d & ~dr_write;
      win_low_word <= win_d & ~dr_write;
      win_wr_err <= win_d & dr_write;
    end
  end
endmodule // amu_addr_mod

// [verif/amu_addr_mod_asserts.sv]
`timescale 1ns/100ps
module amu_addr_mod_asserts (
  input wire mclk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire tbl_valid,
  input wire [15:0] tbl_ea,
  input wire [23:0] tbl_paddr,
  input wire tbl_cfg,
  input wire dr_valid,
  input wire [15:0] dr_ea,
  input wire dr_write,
  input wire [15:0] core_control,
  input wire win_hit,
  input wire [23:0] win_paddr,
  input wire win_wr_err,
  input wire xr_valid,
  input wire [2:0] xr_mode,
  input wire xr_wb_en,
  input wire xw_valid,
  input wire [2:0] xw_mode,
  input wire xw_byte,
  input wire xw_brev_act
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire win_sel = dr_valid && dr_ea[15] && core_control[2];
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack");
  property p_tbl; tbl_valid |=> tbl_paddr[15:0] == $past(tbl_ea) && tbl_cfg == tbl_paddr[23]; endproperty
  a_tbl: assert property (p_tbl) else $error("table address");
  property p_win; win_sel && !dr_write |=> win_hit && !win_paddr[23] && win_paddr[14:0] == $past(dr_ea[14:0]);
  endproperty
  a_win: assert property (p_win) else $error("window address");
  property p_nowin; dr_valid && !(dr_ea[15] && core_control[2]) |=> !win_hit; endproperty
  a_nowin: assert property (p_nowin) else $error("window hit");
  property p_wrerr; win_sel && dr_write |=> win_wr_err && !win_hit; endproperty
  a_wrerr: assert property (p_wrerr) else $error("window write");
  property p_regoff; xr_valid && xr_mode == 3'h5 |=> !xr_wb_en; endproperty
  a_regoff: assert property (p_regoff) else $error("offset writeback");
  property p_byte; xw_valid && xw_byte |=> !xw_brev_act; endproperty
  a_byte: assert property (p_byte) else $error("byte reversed");
  property p_mode; xw_valid && xw_mode != 3'h1 && xw_mode != 3'h2 |=> !xw_brev_act; endproperty
  a_mode: assert property (p_mode) else $error("mode reversed");
  c_brev: cover property (xw_brev_act);
  c_win: cover property (win_hit);
  c_cfg: cover property (tbl_cfg);
endmodule // amu_addr_mod_asserts

// [verif/amu_core_model.sv]
`timescale 1ns/100ps
module amu_core_model (
  input wire mclk,
  output reg [4:0] v,
  output reg [3:0] sel,
  output reg [15:0] ptr,
  output reg [15:0] off,
  output reg [2:0] mode,
  output reg flag
);
  initial begin
    v = 5'h00;
    sel = 4'hF;
    ptr = 16'h0000;
    off = 16'h0000;
    mode = 3'h0;
    flag = 1'b0;
  end
  task req(input [2:0] k, input [3:0] s, input [15:0] p, input [15:0] o, input [2:0] m, input f);
    begin
      @(posedge mclk);
      v <= 5'h01 << k;
      sel <= s;
      ptr <= p;
      off <= o;
      mode <= m;
      flag <= f;
      @(posedge mclk);
      v <= 5'h00;
      // Stale pointer must not look valid
      ptr <= ~p;
      #1;
    end
  endtask
endmodule // amu_core_model

// [verif/amu_addr_mod_test.sv]
`timescale 1ns/100ps
bind amu_addr_mod amu_addr_mod_asserts i_amu_addr_mod_asserts (.*);
module amu_addr_mod_test;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [3:0] wb_adr_i = 4'h0;
  reg [3:0] wb_sel_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg [15:0] xmod_start = 16'h0, xmod_end = 16'h0, ymod_start = 16'h0, ymod_end = 16'h0, core_control = 16'h0;
  wire [31:0] wb_dat_o;
  wire [15:0] xr_ea, xr_wb_val, xw_ea, xw_wb_val, y_ea, y_wb_val, ptr, off;
  wire [23:0] tbl_paddr, win_paddr;
  wire [4:0] v;
  wire [3:0] sel;
  wire [2:0] mode;
  wire wb_ack_o, xr_wb_en, xr_out_valid, xw_wb_en, xw_out_valid, xw_brev_act, y_wb_en, y_out_valid, flag;
  wire tbl_cfg, tbl_out_valid, win_hit, win_low_word, win_wr_err;
  integer errors = 0;
  integer n_tests = 0;
  amu_core_model i_core (.mclk(mclk), .v(v), .sel(sel), .ptr(ptr), .off(off), .mode(mode), .flag(flag));
  amu_addr_mod i_amu_addr_mod (.*, .xr_valid(v[0]), .xw_valid(v[1]), .y_valid(v[2]), .tbl_valid(v[3]),
    .dr_valid(v[4]), .xr_ptr_sel(sel), .xw_ptr_sel(sel), .y_ptr_sel(sel), .xr_ptr(ptr), .xw_ptr(ptr),
    .y_ptr(ptr), .tbl_ea(ptr), .dr_ea(ptr), .xr_off(off), .xw_off(off), .y_off(off), .xr_mode(mode),
    .xw_mode(mode), .y_mode(mode), .xw_byte(flag), .dr_write(flag));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task stop_test;
    begin
      if (errors == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task ck(input [39:0] g, input [39:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wb(input w, input [3:0] a, input [3:0] s, input [15:0] d, input [15:0] e);
    integer t;
    begin
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {16'h0, d};
      t = 0;
      do begin
        @(posedge mclk);
        t = t + 1;
      end while (wb_ack_o !== 1'b1 && t < 20);
      ck({wb_ack_o, w ? {16'h0000, e} : wb_dat_o}, {1'b1, 16'h0000, e});
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      wb(1'b0, 4'h0, 4'h3, 16'h0, 16'h0FFF);
      wb(1'b0, 4'h4, 4'h3, 16'h0, 16'h0);
      wb(1'b0, 4'h8, 4'h3, 16'h0, 16'h0);
      wb(1'b0, 4'hC, 4'h3, 16'h0, 16'h0);
      wb(1'b1, 4'h0, 4'h1, 16'hABCD, 16'h0);
      wb(1'b0, 4'h0, 4'h3, 16'h0, 16'h0FCD);
      wb(1'b1, 4'h2, 4'h3, 16'h5555, 16'h0);
      wb(1'b0, 4'h2, 4'h3, 16'h0, 16'h0);
    end
  endtask
  task t_tbl;
    begin
      wb(1'b1, 4'h8, 4'h3, 16'h0085, 16'h0);
      i_core.req(3'h3, 4'h0, 16'h1234, 16'h0, 3'h0, 1'b0);
      ck({tbl_out_valid, tbl_cfg, tbl_paddr}, {2'h3, 24'h851234});
      wb(1'b1, 4'h8, 4'h3, 16'h0005, 16'h0);
      i_core.req(3'h3, 4'h0, 16'hFFFE, 16'h0, 3'h0, 1'b0);
      ck({tbl_cfg, tbl_paddr}, {1'b0, 24'h05FFFE});
      @(posedge mclk);
      #1;
      ck(tbl_out_valid, 1'b0);
    end
  endtask
  task t_win;
    begin
      wb(1'b1, 4'hC, 4'h3, 16'h003B, 16'h0);
      core_control <= 16'h0004;
      i_core.req(3'h4, 4'h0, 16'hC123, 16'h0, 3'h0, 1'b0);
      ck({win_hit, win_low_word, win_paddr}, {2'h3, 24'h1DC123});
      i_core.req(3'h4, 4'h0, 16'hC123, 16'h0, 3'h0, 1'b1);
      ck({win_hit, win_wr_err}, 2'h1);
      i_core.req(3'h4, 4'h0, 16'h4123, 16'h0, 3'h0, 1'b0);
      ck(win_hit, 1'b0);
    end
  endtask
  task t_xcirc;
    begin
      xmod_start <= 16'h1000;
      xmod_end <= 16'h100F;
      wb(1'b1, 4'h0, 4'h3, 16'h8FF3, 16'h0);
      i_core.req(3'h0, 4'h3, 16'h100E, 16'h4, 3'h2, 1'b0);
      ck({xr_out_valid, xr_wb_en, xr_ea, xr_wb_val}, {2'h3, 32'h10021002});
      i_core.req(3'h0, 4'h3, 16'h100E, 16'h4, 3'h5, 1'b0);
      ck({xr_wb_en, xr_ea}, {1'b0, 16'h1002});
      i_core.req(3'h1, 4'h3, 16'h100E, 16'h4, 3'h2, 1'b0);
      ck({xw_out_valid, xw_wb_en, xw_ea, xw_wb_val}, {2'h3, 32'h10021002});
      wb(1'b1, 4'h0, 4'h3, 16'h8FFF, 16'h0);
      i_core.req(3'h0, 4'h3, 16'h100E, 16'h4, 3'h2, 1'b0);
      ck(xr_ea, 16'h1012);
    end
  endtask
  task t_ycirc;
    begin
      ymod_start <= 16'h2000;
      ymod_end <= 16'h200F;
      wb(1'b1, 4'h0, 4'h3, 16'h4F5F, 16'h0);
      i_core.req(3'h2, 4'h5, 16'h200E, 16'h4, 3'h2, 1'b0);
      ck({y_out_valid, y_wb_en, y_ea, y_wb_val}, {2'h3, 32'h20022002});
      wb(1'b1, 4'h0, 4'h3, 16'h0F5F, 16'h0);
      i_core.req(3'h2, 4'h5, 16'h200E, 16'h4, 3'h2, 1'b0);
      ck(y_ea, 16'h2012);
    end
  endtask
  task t_brev;
    begin
      wb(1'b1, 4'h0, 4'h3, 16'h82F2, 16'h0);
      wb(1'b1, 4'h4, 4'h3, 16'h8008, 16'h0);
      i_core.req(3'h1, 4'h2, 16'h1010, 16'h2, 3'h1, 1'b0);
      ck({xw_brev_act, xw_wb_en, xw_ea, xw_wb_val}, {2'h3, 32'h10101008});
      i_core.req(3'h1, 4'h2, 16'h1000, 16'h2, 3'h2, 1'b0);
      ck({xw_brev_act, xw_ea}, {1'b1, 16'h1010});
      i_core.req(3'h1, 4'h2, 16'h1004, 16'h2, 3'h1, 1'b1);
      ck({xw_brev_act, xw_ea, xw_wb_val}, {1'b0, 32'h10041006});
      i_core.req(3'h1, 4'h2, 16'h1004, 16'hFFFE, 3'h3, 1'b0);
      ck({xw_brev_act, xw_wb_en, xw_ea, xw_wb_val}, {2'h1, 32'h10041002});
      i_core.req(3'h0, 4'h2, 16'h100E, 16'h4, 3'h2, 1'b0);
      ck(xr_ea, 16'h1002);
    end
  endtask
  task t_reset;
    begin
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      ck({tbl_paddr, win_hit, xw_brev_act, xr_out_valid}, 27'h0000000);
      @(posedge mclk);
      rst <= 1'b0;
      wb(1'b0, 4'h0, 4'h3, 16'h0, 16'h0FFF);
      wb(1'b0, 4'h4, 4'h3, 16'h0, 16'h0);
      wb(1'b0, 4'hC, 4'h3, 16'h0, 16'h0);
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_tbl;
    t_win;
    t_xcirc;
    t_ycirc;
    t_brev;
    t_reset;
    stop_test;
  end
  // Run needs about a hundred cycles
  initial begin
    #200000;
    errors = errors + 1;
    stop_test;
  end
endmodule // amu_addr_mod_test
